// File: hw/qpc_pkg.sv
// Shared constants of the quadrature pulse counter: register map, field layout, sizes.
// Assumes a single 200 MHz clock domain and byte addresses on a word-wide register port.
`default_nettype none
package qpc_pkg;
  localparam int NUM_UNITS = 7;
  localparam int NUM_PORTS = 5;
  localparam int NUM_DIN = 16;
  localparam int CNT_W = 32;
  localparam int WIN_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FAULT_W = 8;

  // Byte offsets of the registers
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_WIN_LOW = 8'h08;
  localparam logic [7:0] REG_WIN_HIGH = 8'h0C;
  localparam logic [7:0] REG_CYCLE = 8'h10;
  localparam logic [7:0] REG_PRESET = 8'h14;
  localparam logic [7:0] REG_COUNT = 8'h18;
  localparam logic [7:0] REG_STATE = 8'h1C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK = 8'h24;

  // Control register bit positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_EXT_START = 2;
  localparam int CTRL_CLR_LEVEL = 3;
  localparam int CTRL_CLR_FALL = 4;
  localparam int CTRL_CLR_RISE = 5;
  localparam int CTRL_WIN_PERMIT = 6;
  localparam int CTRL_RESET = 7;
  localparam int CTRL_WRAP = 8;
  localparam int CTRL_PRESET = 9;
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET_VAL = 10'h000;

  // Configuration register fields
  localparam int CFG_UNIT_LSB = 0;
  localparam int CFG_SRC_LSB = 4;
  localparam int CFG_CLR_LSB = 8;
  localparam int CFG_W = 12;
  localparam logic [CFG_W-1:0] CFG_RESET_VAL = 12'h000;

  // State register fields
  localparam int ST_DIR = 0;
  localparam int ST_RUN = 1;
  localparam int ST_UNIT_LSB = 4;
  localparam int ST_FAULT_LSB = 8;

  // Interrupt status bits
  localparam int IRQ_WRAP = 0;
  localparam int IRQ_CLEAR = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W = 3;

  // Fault codes
  localparam logic [FAULT_W-1:0] FAULT_NONE = 8'h00;
  localparam logic [FAULT_W-1:0] FAULT_UNIT = 8'h01;
  localparam logic [FAULT_W-1:0] FAULT_SRC = 8'h02;

  // Digital input that starts each unit when the external start is permitted
  localparam logic [27:0] START_DIN_MAP = {4'hF, 4'hD, 4'hB, 4'h9, 4'h7, 4'h5, 4'h3};

  // Highest pulse rate the counter accepts, and the least clock cycles between edges
  localparam int CLK_MHZ = 200;
  localparam int MAX_PULSE_MHZ = 1;
  localparam int MIN_EDGE_CYCLES = CLK_MHZ / (4 * MAX_PULSE_MHZ);
endpackage
`default_nettype wire

// File: hw/qpc_counter.sv
// Seven-unit quadrature pulse counter with a small register port and one interrupt line.
// Assumes encoder and digital inputs already synchronous to core_clk.
//
// Summary of operation
// R01: Seven counter units; unit number 0-6, default 0, latched when enable rises.
// R02: Pulse source 0-4 selects encoder port zero to four.
// R03: Software raises enable to launch; unit and source take effect then.
// R04: Selected unit counts pulses while start is high.
// R05: Rising external-start permit lets the unit's fixed input start counting.
// R06: Level clearing zeroes the count while the clear input is high.
// R07: Falling-edge clearing zeroes the count on each high-to-low transition.
// R08: Rising-edge clearing zeroes the count on each low-to-high transition.
// R09: Clear index 0-7 selects first input bank, 8-15 the second.
// R10: With window permit, external clear acts only inside low and high bounds.
// R11: Counting is pure hardware, accepting pulse rates up to 1 MHz.
// R12: Encoder ports are decoded as two-phase quadrature A/B signals.
// R13: While reset bit is high, the selected unit's count is cleared.
// R14: With wrap permitted, count reaching cycle value clears and keeps counting.
// R15: While preset-load is high, count is loaded with the preset value.
// R16: Direction flag and current count are driven continuously.
//
// The address map and the strobed register port were left to the implementer.
`default_nettype none
module qpc_counter (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [qpc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [qpc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [qpc_pkg::DATA_W-1:0] regRdata,
  input wire logic [qpc_pkg::NUM_PORTS-1:0] encA,
  input wire logic [qpc_pkg::NUM_PORTS-1:0] encB,
  input wire logic [qpc_pkg::NUM_DIN-1:0] digIn,
  output logic [qpc_pkg::CNT_W-1:0] countOut,
  output logic countDir,
  output logic [qpc_pkg::FAULT_W-1:0] faultCode,
  output logic irq
);
  logic [qpc_pkg::CTRL_W-1:0] ctrl;
  logic [qpc_pkg::CFG_W-1:0] cfg;
  logic [qpc_pkg::WIN_W-1:0] winLow;
  logic [qpc_pkg::WIN_W-1:0] winHigh;
  logic [qpc_pkg::CNT_W-1:0] cycleVal;
  logic [qpc_pkg::CNT_W-1:0] presetVal;
  logic [qpc_pkg::IRQ_W-1:0] irqStat;
  logic [qpc_pkg::IRQ_W-1:0] irqMask;
  logic [2:0] selUnit;
  logic enPrev;
  logic extPrev;
  logic clrPrev;
  logic [qpc_pkg::NUM_PORTS-1:0] prevA;
  logic [qpc_pkg::NUM_PORTS-1:0] prevB;
  logic [qpc_pkg::NUM_PORTS-1:0] stepEn;
  logic [qpc_pkg::NUM_PORTS-1:0] stepUp;
  logic [qpc_pkg::NUM_UNITS-1:0][qpc_pkg::CNT_W-1:0] cntAll;
  logic [qpc_pkg::NUM_UNITS-1:0] dirAll;
  logic [qpc_pkg::NUM_UNITS-1:0] runAll;
  logic [qpc_pkg::NUM_UNITS-1:0] wrapAll;
  logic [2:0] cfgUnit;
  logic [2:0] cfgSrc;
  logic [3:0] clrIdx;
  logic enRise;
  logic extRise;
  logic clrLevelIn;
  logic clrHit;
  logic inWindow;
  logic launchOk;
  logic [qpc_pkg::CNT_W-1:0] selCount;
  logic [qpc_pkg::IRQ_W-1:0] irqEvent;
  logic [qpc_pkg::DATA_W-1:0] next_regRdata;

  assign cfgUnit = cfg[qpc_pkg::CFG_UNIT_LSB +: 3];
  assign cfgSrc = cfg[qpc_pkg::CFG_SRC_LSB +: 3];
  assign clrIdx = cfg[qpc_pkg::CFG_CLR_LSB +: 4];

  // Launch edges; a bad unit or source number refuses the launch
  assign enRise = ctrl[qpc_pkg::CTRL_ENABLE] & ~enPrev; // R03
  assign extRise = ctrl[qpc_pkg::CTRL_EXT_START] & ~extPrev; // R05
  assign launchOk = (cfgUnit < 3'(qpc_pkg::NUM_UNITS)) && (cfgSrc < 3'(qpc_pkg::NUM_PORTS));

  // Clear source: index picks one of sixteen inputs, banks of eight
  assign clrLevelIn = digIn[clrIdx]; // R09
  assign selCount = cntAll[selUnit];
  // Window bounds are unsigned 16-bit values; a negative count is outside any window
  assign inWindow = !ctrl[qpc_pkg::CTRL_WIN_PERMIT] ||
    (!selCount[qpc_pkg::CNT_W-1] &&
     selCount >= {16'h0000, winLow} && selCount <= {16'h0000, winHigh}); // R10
  assign clrHit = inWindow && (
    (ctrl[qpc_pkg::CTRL_CLR_LEVEL] && clrLevelIn) || // R06
    (ctrl[qpc_pkg::CTRL_CLR_FALL] && clrPrev && !clrLevelIn) || // R07
    (ctrl[qpc_pkg::CTRL_CLR_RISE] && !clrPrev && clrLevelIn)); // R08

  // Edge history for the control bits and the clear input
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enPrev <= 1'b0;
      extPrev <= 1'b0;
      clrPrev <= 1'b0;
    end else begin
      enPrev <= ctrl[qpc_pkg::CTRL_ENABLE];
      extPrev <= ctrl[qpc_pkg::CTRL_EXT_START];
      clrPrev <= clrLevelIn;
    end
  end

  // Unit number is taken only on the enable rising edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      selUnit <= 3'h0;
      faultCode <= qpc_pkg::FAULT_NONE;
    end else if (enRise) begin
      if (cfgUnit >= 3'(qpc_pkg::NUM_UNITS)) begin
        faultCode <= qpc_pkg::FAULT_UNIT;
      end else if (cfgSrc >= 3'(qpc_pkg::NUM_PORTS)) begin
        faultCode <= qpc_pkg::FAULT_SRC;
      end else begin
        selUnit <= cfgUnit; // R01
        faultCode <= qpc_pkg::FAULT_NONE;
      end
    end
  end

  // Quadrature decode per port; a double-phase change is a glitch and is dropped
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prevA <= '0;
      prevB <= '0;
    end else begin
      prevA <= encA;
      prevB <= encB;
    end
  end

  // Full x4 decode; at 200 MHz each edge of a 1 MHz A/B pair is seen many times over
  assign stepEn = (encA ^ prevA) ^ (encB ^ prevB); // R12 R11
  assign stepUp = prevA ^ encB; // R12

  // One counter per unit, all running in parallel on every clock
  genvar gi;
  generate
    for (gi = 0; gi < qpc_pkg::NUM_UNITS; gi++) begin : gUnit
      logic [2:0] src;
      logic run;
      logic armed;
      logic dir;
      logic [qpc_pkg::CNT_W-1:0] cnt;
      logic [qpc_pkg::CNT_W-1:0] stepped;
      logic [qpc_pkg::CNT_W-1:0] next_cnt;
      logic isSel;
      logic wrapHit;
      logic startIn;

      assign isSel = (selUnit == 3'(gi));
      assign startIn = digIn[qpc_pkg::START_DIN_MAP[gi*4 +: 4]];

      // Source and external-start arming follow the launch and permit edges
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          src <= 3'h0;
          armed <= 1'b0;
        end else begin
          if (enRise && launchOk && cfgUnit == 3'(gi)) begin
            src <= cfgSrc; // R02 R03
          end
          if (isSel && extRise) begin
            armed <= 1'b1; // R05
          end else if (isSel && !ctrl[qpc_pkg::CTRL_EXT_START]) begin
            armed <= 1'b0;
          end
        end
      end

      // Run state of the selected unit tracks start; others keep their last state
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          run <= 1'b0;
        end else if (isSel) begin
          run <= ctrl[qpc_pkg::CTRL_START] || (armed && startIn); // R04 R05
        end
      end

      assign stepped = !(run && stepEn[src]) ? cnt :
        stepUp[src] ? cnt + 32'h00000001 : cnt - 32'h00000001; // R04
      assign wrapHit = isSel && ctrl[qpc_pkg::CTRL_WRAP] &&
        (run && stepEn[src]) && stepped == cycleVal; // R14

      // Priority: reset, preset, external clear, wrap, then counting
      always_comb begin
        next_cnt = stepped;
        if (wrapHit) begin
          next_cnt = '0; // R14
        end
        if (isSel && clrHit) begin
          next_cnt = '0; // R06 R07 R08
        end
        if (isSel && ctrl[qpc_pkg::CTRL_PRESET]) begin
          next_cnt = presetVal; // R15
        end
        if (isSel && ctrl[qpc_pkg::CTRL_RESET]) begin
          next_cnt = '0; // R13
        end
      end

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          cnt <= '0;
          dir <= 1'b0;
        end else begin
          cnt <= next_cnt;
          if (run && stepEn[src]) begin
            dir <= stepUp[src]; // R16
          end
        end
      end

      assign cntAll[gi] = cnt;
      assign dirAll[gi] = dir;
      assign runAll[gi] = run;
      assign wrapAll[gi] = wrapHit;
    end
  endgenerate

  // Count and direction of the selected unit, registered for clean outputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      countOut <= '0;
      countDir <= 1'b0;
    end else begin
      countOut <= selCount; // R16
      countDir <= dirAll[selUnit]; // R16
    end
  end

  // Software-written registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl <= qpc_pkg::CTRL_RESET_VAL;
      cfg <= qpc_pkg::CFG_RESET_VAL;
      winLow <= '0;
      winHigh <= '0;
      cycleVal <= '0;
      presetVal <= '0;
      irqMask <= '0;
    end else if (regWr) begin
      case (regAddr)
        qpc_pkg::REG_CTRL: ctrl <= regWdata[qpc_pkg::CTRL_W-1:0];
        qpc_pkg::REG_CFG: cfg <= regWdata[qpc_pkg::CFG_W-1:0];
        qpc_pkg::REG_WIN_LOW: winLow <= regWdata[qpc_pkg::WIN_W-1:0];
        qpc_pkg::REG_WIN_HIGH: winHigh <= regWdata[qpc_pkg::WIN_W-1:0];
        qpc_pkg::REG_CYCLE: cycleVal <= regWdata;
        qpc_pkg::REG_PRESET: presetVal <= regWdata;
        qpc_pkg::REG_IRQ_MASK: irqMask <= regWdata[qpc_pkg::IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky events; a new event in the clearing cycle survives the write of one
  assign irqEvent[qpc_pkg::IRQ_WRAP] = |wrapAll;
  assign irqEvent[qpc_pkg::IRQ_CLEAR] = clrHit;
  assign irqEvent[qpc_pkg::IRQ_FAULT] = enRise && !launchOk;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqStat <= '0;
    end else if (regWr && regAddr == qpc_pkg::REG_IRQ_STAT) begin
      irqStat <= (irqStat & ~regWdata[qpc_pkg::IRQ_W-1:0]) | irqEvent;
    end else begin
      irqStat <= irqStat | irqEvent;
    end
  end

  assign irq = |(irqStat & irqMask);

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_regRdata = '0;
    case (regAddr)
      qpc_pkg::REG_CTRL: next_regRdata[qpc_pkg::CTRL_W-1:0] = ctrl;
      qpc_pkg::REG_CFG: next_regRdata[qpc_pkg::CFG_W-1:0] = cfg;
      qpc_pkg::REG_WIN_LOW: next_regRdata[qpc_pkg::WIN_W-1:0] = winLow;
      qpc_pkg::REG_WIN_HIGH: next_regRdata[qpc_pkg::WIN_W-1:0] = winHigh;
      qpc_pkg::REG_CYCLE: next_regRdata = cycleVal;
      qpc_pkg::REG_PRESET: next_regRdata = presetVal;
      qpc_pkg::REG_COUNT: next_regRdata = selCount;
      qpc_pkg::REG_STATE: begin
        next_regRdata[qpc_pkg::ST_DIR] = dirAll[selUnit];
        next_regRdata[qpc_pkg::ST_RUN] = runAll[selUnit];
        next_regRdata[qpc_pkg::ST_UNIT_LSB +: 3] = selUnit;
        next_regRdata[qpc_pkg::ST_FAULT_LSB +: qpc_pkg::FAULT_W] = faultCode;
      end
      qpc_pkg::REG_IRQ_STAT: next_regRdata[qpc_pkg::IRQ_W-1:0] = irqStat;
      qpc_pkg::REG_IRQ_MASK: next_regRdata[qpc_pkg::IRQ_W-1:0] = irqMask;
      default: next_regRdata = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regRdata <= '0;
    end else if (regRd) begin
      regRdata <= next_regRdata;
    end else begin
      regRdata <= '0;
    end
  end
endmodule
`default_nettype wire

// File: dv/qpc_enc_model.sv
// Encoder stand-in that drives the five quadrature ports of the counter.
// Assumes the bench spaces its step requests to respect the pulse-rate limit.
`default_nettype none
module qpc_enc_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic stepGo,
  input wire logic [2:0] stepPort,
  input wire logic stepUp,
  output logic [qpc_pkg::NUM_PORTS-1:0] encA,
  output logic [qpc_pkg::NUM_PORTS-1:0] encB
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph [qpc_pkg::NUM_PORTS];
  // One phase move per request, so A and B never change together
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < qpc_pkg::NUM_PORTS; i++) ph[i] <= 2'h0;
    end else if (stepGo) begin
      ph[stepPort] <= stepUp ? ph[stepPort] + 2'h1 : ph[stepPort] - 2'h1;
    end
  end
  // Gray-coded phases; B moves first on an up step
  always_comb begin
    for (int i = 0; i < qpc_pkg::NUM_PORTS; i++) begin
      encA[i] = ph[i][1];
      encB[i] = ph[i][1] ^ ph[i][0];
    end
  end
endmodule
`default_nettype wire

// File: dv/qpc_counter_chk.sv
// Port checker of the pulse counter, with shadows of CTRL, CFG and PRESET.
// Assumes registers change only through the register port.
`default_nettype none
module qpc_counter_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [qpc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [qpc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [qpc_pkg::DATA_W-1:0] regRdata,
  input wire logic [qpc_pkg::NUM_DIN-1:0] digIn,
  input wire logic [qpc_pkg::CNT_W-1:0] countOut,
  input wire logic [qpc_pkg::FAULT_W-1:0] faultCode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ctl;
  logic [31:0] cfg;
  logic [31:0] pre;
  wire logic clrIn = digIn[cfg[11:8]];
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Shadows let each property name its cause at the pins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctl <= '0;
      cfg <= '0;
      pre <= '0;
    end else if (regWr) begin
      if (regAddr == qpc_pkg::REG_CTRL) ctl <= regWdata;
      if (regAddr == qpc_pkg::REG_CFG) cfg <= regWdata;
      if (regAddr == qpc_pkg::REG_PRESET) pre <= regWdata;
    end
  end
  property p_rd_idle;
    !$past(regRd) |-> regRdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_cnt_rd;
    $past(regRd && regAddr == qpc_pkg::REG_COUNT) |-> regRdata == countOut;
  endproperty
  a_cnt_rd: assert property (p_cnt_rd) else $error("count read differs");
  property p_reset;
    ctl[qpc_pkg::CTRL_RESET] [*3] |-> countOut == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("count not held at zero");
  property p_preset;
    (ctl[qpc_pkg::CTRL_PRESET] && !ctl[qpc_pkg::CTRL_RESET]) [*3] |-> countOut == pre;
  endproperty
  a_preset: assert property (p_preset) else $error("preset not loaded");
  property p_level;
    (ctl[qpc_pkg::CTRL_CLR_LEVEL] && ctl[9:6] == 4'h0 && clrIn) [*3] |-> countOut == '0;
  endproperty
  a_level: assert property (p_level) else $error("level clear missed");
  property p_unit;
    $rose(ctl[qpc_pkg::CTRL_ENABLE]) && cfg[2:0] == 3'h7 |-> ##[1:4] faultCode == 8'h01;
  endproperty
  a_unit: assert property (p_unit) else $error("bad unit not refused");
  property p_src;
    $rose(ctl[0]) && cfg[2:0] != 3'h7 && cfg[6:4] > 3'h4 |-> ##[1:4] faultCode == 8'h02;
  endproperty
  a_src: assert property (p_src) else $error("bad source not refused");
  // Without controls the count moves at most one step per cycle
  property p_step;
    (ctl[9:3] == 7'h00 && ctl[0]) [*8] |->
      countOut - $past(countOut) inside {32'h0, 32'h1, 32'hFFFFFFFF};
  endproperty
  a_step: assert property (p_step) else $error("count jumped");
  c_fault: cover property (faultCode == qpc_pkg::FAULT_SRC);
  c_level: cover property (ctl[qpc_pkg::CTRL_CLR_LEVEL] && clrIn);
  c_count: cover property (regRd && regAddr == qpc_pkg::REG_COUNT);
endmodule
bind qpc_counter qpc_counter_chk chk (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .digIn(digIn),
  .countOut(countOut), .faultCode(faultCode));
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench: register tasks, encoder stand-in and a count model per unit.
// Assumes the checker is bound from its own file; one 200 MHz clock.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0, rst_n = 1'h0, regWr = 1'h0, regRd = 1'h0;
  logic stepGo = 1'h0, stepUp = 1'h0, countDir, irq;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] faultCode;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  logic [31:0] countOut;
  logic [4:0] encA;
  logic [4:0] encB;
  logic [15:0] digIn = 16'h0;
  logic [2:0] stepPort = 3'h0;
  int n_errors = 0, compares = 0, seed = 32'h3283;
  int cnt[7], sel = 0, run = 0, wrapOn = 0, cyc = 5;
  always #2.5 core_clk = ~core_clk;
  qpc_counter uut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .encA(encA),
    .encB(encB), .digIn(digIn), .countOut(countOut), .countDir(countDir),
    .faultCode(faultCode), .irq(irq));
  qpc_enc_model enc (.core_clk(core_clk), .rst_n(rst_n), .stepGo(stepGo),
    .stepPort(stepPort), .stepUp(stepUp), .encA(encA), .encB(encB));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'h0;
  endtask
  task automatic rdchk(string what, logic [7:0] a, logic [31:0] exp);
    @(posedge core_clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'h0;
    #1 chk(what, exp, regRdata);
  endtask
  // Enable is taken low then high, so unit and source are latched again
  task automatic launch(int u, int s, int c);
    wr(qpc_pkg::REG_CFG, 32'(c * 256 + s * 16 + u));
    wr(qpc_pkg::REG_CTRL, 32'h0);
    wr(qpc_pkg::REG_CTRL, 32'h1);
    repeat (4) @(posedge core_clk);
    #1 run = 0;
    if (u < 7 && s < 5) begin
      sel = u;
      stepPort <= 3'(s);
    end
  endtask
  // One encoder step, spaced for the highest pulse rate, then model and compare
  task automatic step(bit up);
    @(posedge core_clk);
    stepGo <= 1'h1;
    stepUp <= up;
    @(posedge core_clk);
    stepGo <= 1'h0;
    repeat (qpc_pkg::MIN_EDGE_CYCLES) @(posedge core_clk);
    #1;
    if (run) begin
      cnt[sel] = up ? cnt[sel] + 1 : cnt[sel] - 1;
      if (wrapOn && cnt[sel] == cyc) cnt[sel] = 0;
      chk("countDir", 32'(up), 32'(countDir));
    end
    chk("countOut", cnt[sel], countOut);
  endtask
  // Waits for a control to settle; z says the count should now be zero
  task automatic hold(bit z);
    repeat (4) @(posedge core_clk);
    #1;
    if (z) cnt[sel] = 0;
    chk("countOut", cnt[sel], countOut);
  endtask
  // Digital inputs move at a rising edge, like every other design input
  task automatic din(int b, bit v);
    @(posedge core_clk);
    digIn[b] <= v;
  endtask
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // A hang is cut well beyond the few thousand cycles the tests need
  initial begin
    #60us;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    // All registers start at zero; the last address is unmapped
    for (int a = 0; a <= 40; a += 4) rdchk("reset read", 8'(a), 32'h0);
    // Last unit on the last port, then unit two on the first port, random directions
    for (int k = 0; k < 2; k++) begin
      launch(k ? 2 : 6, k ? 0 : 4, 9);
      step(1'h1);
      wr(qpc_pkg::REG_CTRL, 32'h3);
      run = 1;
      repeat (10) step(1'($random(seed)));
      rdchk("count reg", qpc_pkg::REG_COUNT, cnt[sel]);
    end
    // Refused launches raise the fault event; the mask gates the line
    wr(qpc_pkg::REG_IRQ_MASK, 32'h3);
    launch(7, 0, 9);
    chk("faultCode", qpc_pkg::FAULT_UNIT, faultCode);
    chk("irq masked", 32'h0, 32'(irq));
    rdchk("irq status", qpc_pkg::REG_IRQ_STAT, 32'h4);
    wr(qpc_pkg::REG_IRQ_MASK, 32'h7);
    #1 chk("irq", 32'h1, 32'(irq));
    wr(qpc_pkg::REG_IRQ_STAT, 32'h4);
    #1 chk("irq cleared", 32'h0, 32'(irq));
    launch(0, 5, 9);
    chk("faultCode", qpc_pkg::FAULT_SRC, faultCode);
    // Reset bit, then a negative preset from which counting resumes
    launch(2, 0, 9);
    wr(qpc_pkg::REG_CTRL, 32'h83);
    hold(1'h1);
    wr(qpc_pkg::REG_PRESET, 32'hFFFFFFFE);
    wr(qpc_pkg::REG_CTRL, 32'h203);
    cnt[sel] = -2;
    hold(1'h0);
    wr(qpc_pkg::REG_CTRL, 32'h3);
    run = 1;
    step(1'h1);
    // Level, falling and rising clears from the second bank
    for (int m = 3; m <= 5; m++) begin
      wr(qpc_pkg::REG_CTRL, 32'h3 | (32'h1 << m));
      step(1'h1);
      step(1'h1);
      din(9, 1'h1);
      hold(m != 4);
      din(9, 1'h0);
      hold(m == 4);
    end
    // First bank clear, honoured only inside the window
    launch(2, 0, 2);
    wr(qpc_pkg::REG_WIN_LOW, 32'hA);
    wr(qpc_pkg::REG_WIN_HIGH, 32'h14);
    wr(qpc_pkg::REG_CTRL, 32'h4B);
    run = 1;
    repeat (3) step(1'h1);
    din(2, 1'h1);
    hold(1'h0);
    wr(qpc_pkg::REG_WIN_LOW, 32'h0);
    hold(1'h1);
    din(2, 1'h0);
    // Clears since the fault launch have raised the clear event beside the fault
    rdchk("irq status", qpc_pkg::REG_IRQ_STAT, 32'h6);
    // Wrap at the cycle value raises only the wrap event
    wr(qpc_pkg::REG_IRQ_STAT, 32'h7);
    wr(qpc_pkg::REG_CYCLE, 32'(cyc));
    wr(qpc_pkg::REG_CTRL, 32'h103);
    wrapOn = 1;
    repeat (6) step(1'h1);
    rdchk("irq status", qpc_pkg::REG_IRQ_STAT, 32'h1);
    rdchk("cycle reg", qpc_pkg::REG_CYCLE, 32'(cyc));
    wrapOn = 0;
    // External start: the unit's own input gates counting after the permit rises
    launch(3, 1, 0);
    wr(qpc_pkg::REG_CTRL, 32'h5);
    step(1'h1);
    din(qpc_pkg::START_DIN_MAP[15:12], 1'h1);
    run = 1;
    repeat (2) step(1'h1);
    // State word: up direction, running, unit three, no fault
    rdchk("state reg", qpc_pkg::REG_STATE, 32'h00000033);
    tally_and_finish;
  end
endmodule
`default_nettype wire
